// >>> core/e1tsl_pkg.sv
// Constants shared by the E1 transmit signalling and loopback control block
package e1tsl_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_MF_ALIGN = 8'h13;
    localparam logic [7:0] ADDR_LINK_SEL = 8'h14;
    localparam logic [7:0] ADDR_CODE_LOOP = 8'h15;
    localparam logic [7:0] ADDR_TX_ALARM = 8'h16;
    localparam logic [7:0] ADDR_SIG_MODE = 8'h17;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // ==========================================================
    // Reset values and writable bit masks
    localparam logic [7:0] RST_MF_ALIGN = 8'h0f;
    localparam logic [7:0] RST_LINK_SEL = 8'h00;
    localparam logic [7:0] RST_CODE_LOOP = 8'h00;
    localparam logic [7:0] RST_TX_ALARM = 8'h00;
    localparam logic [7:0] RST_SIG_MODE = 8'h00;
    localparam logic [7:0] WMASK_LINK_SEL = 8'he0;
    localparam logic [7:0] WMASK_CODE_LOOP = 8'h7f;
    localparam logic [7:0] WMASK_SIG_MODE = 8'h03;
    // ==========================================================
    // Field positions: multiframe alignment word
    localparam int MF_X1 = 3;
    localparam int MF_Y = 2;
    // Link controller select word
    localparam int LS_NATIONAL = 7;
    localparam int LS_SLOT16 = 6;
    localparam int LS_RX_TRANSP = 5;
    // Coding and loopback word
    localparam int CL_METALLIC = 6;
    localparam int CL_AMI = 5;
    localparam int CL_MF_RESEARCH = 4;
    localparam int CL_DIGITAL = 3;
    localparam int CL_REMOTE = 2;
    localparam int CL_BACKPLANE = 1;
    localparam int CL_PAYLOAD = 0;
    // Transmit alarm word
    localparam int TA_ALL_ONES = 7;
    localparam int TA_SLOT0 = 6;
    localparam int TA_SLOT16 = 5;
    localparam int TA_E_FILL = 4;
    localparam int TA_FR_RESEARCH = 3;
    localparam int TA_FP_RATE = 2;
    localparam int TA_DATA_OFF = 1;
    localparam int TA_SIG_OFF = 0;
    // Signalling mode word
    localparam int SM_Y_MANUAL = 0;
    localparam int SM_CCS = 1;
    // ==========================================================
    // Frame positions and frame pulse divider
    localparam logic [4:0] SLOT_ZERO = 5'h00;
    localparam logic [4:0] SLOT_SIG = 5'h10;
    localparam logic [3:0] FRAME_ZERO = 4'h0;
    localparam int FP_64K_BIT = 4;
    localparam logic [7:0] FP_8K_COUNT = 8'hff;
endpackage

// >>> core/e1tsl_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module e1tsl_pin_sync
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic pin_in,
    output logic sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ==========================================================
    // Stage one feeds only stage two, to contain metastability
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else if (ce)
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            sync_out <= 1'b0;
        else if (ce && (s2_reg == s3_reg))
            sync_out <= s3_reg;
    end
endmodule

// >>> core/e1tsl_ctrl.sv
// E1 transmit signalling word, loopback, alarm and output control block
// ==========================================================
// What this block does
// - Send the four alignment pattern bits in slot 16 bits 1-4, frame zero
// - Send spare bit A in slot 16 bit 5, frame zero; resets to one
// - Manual mode sends programmed remote loss bit in bit 6; automatic ignores it
// - Send spare bits B and C in slot 16 bits 7-8; reset to one
// - National bit controller attached when selected; else detached, interrupts masked
// - Slot 16 controller attached in common channel mode when selected; interrupts masked only when deselected
// - Receive transparent mode disables receive framing, raw data to backplane
// - Metallic loop feeds transmit line into receiver; isolating the line inputs is left to logic outside
// - Coding bit zero means HDB3 on transmit, one means AMI; receive always HDB3
// - Multiframe search starts on one-to-zero of its bit; software holds a frame
// - Digital loop feeds transmit line stream in place of receive line stream
// - Remote loop routes line receive pins straight to line transmit pins
// - Backplane loop connects backplane input to backplane output
// - Payload loop returns received slots except slot zero to the line
// - Alarm bit forces all ones on the whole transmit line
// - Slot zero alarm bit forces all ones in slot zero only
// - Slot 16 alarm bit forces all ones in slot 16 when the payload loop is off
// - E-bits carry comparison results when CRC sync holds, else the fill bit
// - Frame search starts on one-to-zero of its bit; software holds a frame
// - Frame pulse output is 64 kHz when selected, else 8 kHz
// - Data output disable tristates on signal, frame, CRC loss or alarm
// - Signalling output disable tristates on multiframe loss or slot 16 alarm
// - Automatic mode fills remote loss bit with own multiframe alignment state
// - Mode bit selects common channel signalling when one, associated when zero
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module e1tsl_ctrl
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_bit_strobe,
    input wire logic [4:0] tx_slot,
    input wire logic [2:0] tx_bit_idx,
    input wire logic [3:0] tx_frame,
    input wire logic tx_framer_bit,
    input wire logic rx_payload_bit,
    input wire logic slot16_link_tx_bit,
    output logic tx_bit_out,
    input wire logic crc_compare_bit,
    output logic tx_e_bit,
    input wire logic signal_loss,
    input wire logic frame_loss,
    input wire logic crc_frame_loss,
    input wire logic multiframe_loss,
    input wire logic ais_seen,
    input wire logic slot16_alarm_seen,
    input wire logic line_rx_pos,
    input wire logic line_rx_neg,
    input wire logic enc_tx_pos,
    input wire logic enc_tx_neg,
    output logic line_tx_pos,
    output logic line_tx_neg,
    output logic dec_rx_pos,
    output logic dec_rx_neg,
    input wire logic bp_data_in,
    input wire logic rx_framer_data,
    output logic bp_data_out,
    output logic bp_data_out_oe,
    input wire logic rx_sig_data,
    output logic bp_sig_out,
    output logic bp_sig_out_oe,
    output logic hdb3_enable,
    output logic rx_framing_off,
    output logic tx_common_sig_mode,
    output logic national_bit_link_ctrl,
    output logic slot16_link_ctrl,
    input wire logic national_link_irq_in,
    input wire logic slot16_link_irq_in,
    output logic national_link_irq,
    output logic slot16_link_irq,
    output logic mf_search_start,
    output logic frame_search_start,
    input wire logic rx_clk_strobe,
    output logic rx_frame_pulse_out
);
    logic [7:0] mf_align_reg;
    logic [7:0] link_sel_reg;
    logic [7:0] code_loop_reg;
    logic [7:0] tx_alarm_reg;
    logic [7:0] sig_mode_reg;
    logic [7:0] rdata_next;
    logic [7:0] status_word;
    logic [7:0] slot16_word;
    logic [7:0] fp_cnt_reg;
    logic mf_research_prev;
    logic fr_research_prev;
    logic rx_pos_s;
    logic rx_neg_s;
    logic bp_in_s;
    logic tx_next;
    logic y_bit;
    logic data_off;
    logic sig_off;
    logic wr_en;

    assign wr_en = ce && reg_wr;

    // ==========================================================
    // Pin synchronisers
    e1tsl_pin_sync u_sync_rx_pos
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .pin_in(line_rx_pos), .sync_out(rx_pos_s)
    );

    e1tsl_pin_sync u_sync_rx_neg
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .pin_in(line_rx_neg), .sync_out(rx_neg_s)
    );

    e1tsl_pin_sync u_sync_bp_in
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .pin_in(bp_data_in), .sync_out(bp_in_s)
    );

    // ==========================================================
    // Control registers, defaults applied at reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            mf_align_reg <= e1tsl_pkg::RST_MF_ALIGN;
            link_sel_reg <= e1tsl_pkg::RST_LINK_SEL;
            code_loop_reg <= e1tsl_pkg::RST_CODE_LOOP;
            tx_alarm_reg <= e1tsl_pkg::RST_TX_ALARM;
            sig_mode_reg <= e1tsl_pkg::RST_SIG_MODE;
        end
        else if (wr_en)
        begin
            case (reg_addr)
                e1tsl_pkg::ADDR_MF_ALIGN: mf_align_reg <= reg_wdata;
                e1tsl_pkg::ADDR_LINK_SEL: link_sel_reg <= reg_wdata & e1tsl_pkg::WMASK_LINK_SEL;
                e1tsl_pkg::ADDR_CODE_LOOP:
                    code_loop_reg <= reg_wdata & e1tsl_pkg::WMASK_CODE_LOOP;
                e1tsl_pkg::ADDR_TX_ALARM: tx_alarm_reg <= reg_wdata;
                e1tsl_pkg::ADDR_SIG_MODE: sig_mode_reg <= reg_wdata & e1tsl_pkg::WMASK_SIG_MODE;
                default: ;
            endcase
        end
    end

    // Status word shows live conditions and the output drive state
    assign status_word = {3'h0, rx_frame_pulse_out, ~bp_sig_out_oe,
        ~bp_data_out_oe, crc_frame_loss, multiframe_loss};

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            e1tsl_pkg::ADDR_MF_ALIGN: rdata_next = mf_align_reg;
            e1tsl_pkg::ADDR_LINK_SEL: rdata_next = link_sel_reg;
            e1tsl_pkg::ADDR_CODE_LOOP: rdata_next = code_loop_reg;
            e1tsl_pkg::ADDR_TX_ALARM: rdata_next = tx_alarm_reg;
            e1tsl_pkg::ADDR_SIG_MODE: rdata_next = sig_mode_reg;
            e1tsl_pkg::ADDR_STATUS: rdata_next = status_word;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (ce)
            reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end

    // ==========================================================
    // Mode outputs straight from the control bits
    assign hdb3_enable = ~code_loop_reg[e1tsl_pkg::CL_AMI];
    assign rx_framing_off = link_sel_reg[e1tsl_pkg::LS_RX_TRANSP];
    assign tx_common_sig_mode = sig_mode_reg[e1tsl_pkg::SM_CCS];
    assign national_bit_link_ctrl = link_sel_reg[e1tsl_pkg::LS_NATIONAL];
    // Slot 16 controller only makes sense in common channel mode
    assign slot16_link_ctrl = link_sel_reg[e1tsl_pkg::LS_SLOT16] & tx_common_sig_mode;
    // Deselected controllers get their interrupts masked
    assign national_link_irq = national_link_irq_in & national_bit_link_ctrl;
    assign slot16_link_irq = slot16_link_irq_in & link_sel_reg[e1tsl_pkg::LS_SLOT16];

    // ==========================================================
    // Reframe requests act on the falling edge of the control bit
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            mf_research_prev <= 1'b0;
            fr_research_prev <= 1'b0;
            mf_search_start <= 1'b0;
            frame_search_start <= 1'b0;
        end
        else if (ce)
        begin
            mf_research_prev <= code_loop_reg[e1tsl_pkg::CL_MF_RESEARCH];
            fr_research_prev <= tx_alarm_reg[e1tsl_pkg::TA_FR_RESEARCH];
            mf_search_start <= mf_research_prev
                & ~code_loop_reg[e1tsl_pkg::CL_MF_RESEARCH];
            frame_search_start <= fr_research_prev
                & ~tx_alarm_reg[e1tsl_pkg::TA_FR_RESEARCH];
        end
    end

    // ==========================================================
    // Slot 16 frame zero word; automatic mode reports own alignment
    assign y_bit = sig_mode_reg[e1tsl_pkg::SM_Y_MANUAL] ?
        mf_align_reg[e1tsl_pkg::MF_Y] : multiframe_loss;
    assign slot16_word = {mf_align_reg[7:3], y_bit, mf_align_reg[1:0]};

    // Transmit bit select; line and slot zero alarms outrank loops, slot 16 alarm outranks signalling only
    always_comb
    begin
        if (tx_alarm_reg[e1tsl_pkg::TA_ALL_ONES])
            tx_next = 1'b1;
        else if (tx_slot == e1tsl_pkg::SLOT_ZERO)
            tx_next = tx_alarm_reg[e1tsl_pkg::TA_SLOT0] | tx_framer_bit;
        else if (code_loop_reg[e1tsl_pkg::CL_PAYLOAD])
            tx_next = rx_payload_bit;
        else if (tx_slot == e1tsl_pkg::SLOT_SIG)
        begin
            if (tx_alarm_reg[e1tsl_pkg::TA_SLOT16])
                tx_next = 1'b1;
            else if (slot16_link_ctrl)
                tx_next = slot16_link_tx_bit;
            else if (!tx_common_sig_mode && tx_frame == e1tsl_pkg::FRAME_ZERO)
                tx_next = slot16_word[3'h7 - tx_bit_idx];
            else
                tx_next = tx_framer_bit;
        end
        else
            tx_next = tx_framer_bit;
    end

    // Transmit bit and E-bit advance on the framer bit strobe
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            tx_bit_out <= 1'b1;
            tx_e_bit <= 1'b0;
        end
        else if (ce && tx_bit_strobe)
        begin
            tx_bit_out <= tx_next;
            tx_e_bit <= crc_frame_loss ? tx_alarm_reg[e1tsl_pkg::TA_E_FILL]
                : crc_compare_bit;
        end
    end

    // ==========================================================
    // Metallic and digital loops feed encoder to decoder; isolation is outside
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            line_tx_pos <= 1'b0;
            line_tx_neg <= 1'b0;
            dec_rx_pos <= 1'b0;
            dec_rx_neg <= 1'b0;
        end
        else if (ce)
        begin
            line_tx_pos <= code_loop_reg[e1tsl_pkg::CL_REMOTE] ? rx_pos_s : enc_tx_pos;
            line_tx_neg <= code_loop_reg[e1tsl_pkg::CL_REMOTE] ? rx_neg_s : enc_tx_neg;
            if (code_loop_reg[e1tsl_pkg::CL_METALLIC] || code_loop_reg[e1tsl_pkg::CL_DIGITAL])
            begin
                dec_rx_pos <= enc_tx_pos;
                dec_rx_neg <= enc_tx_neg;
            end
            else
            begin
                dec_rx_pos <= rx_pos_s;
                dec_rx_neg <= rx_neg_s;
            end
        end
    end

    // ==========================================================
    // Backplane outputs and their conditional tristate
    assign data_off = tx_alarm_reg[e1tsl_pkg::TA_DATA_OFF]
        & (signal_loss | frame_loss | crc_frame_loss | ais_seen);
    assign sig_off = tx_alarm_reg[e1tsl_pkg::TA_SIG_OFF]
        & (multiframe_loss | slot16_alarm_seen);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            bp_data_out <= 1'b1;
            bp_sig_out <= 1'b1;
            bp_data_out_oe <= 1'b1;
            bp_sig_out_oe <= 1'b1;
        end
        else if (ce)
        begin
            // Transparent data already arrives unframed on rx_framer_data
            bp_data_out <= code_loop_reg[e1tsl_pkg::CL_BACKPLANE] ?
                bp_in_s : rx_framer_data;
            bp_sig_out <= rx_sig_data;
            bp_data_out_oe <= ~data_off;
            bp_sig_out_oe <= ~sig_off;
        end
    end

    // ==========================================================
    // Frame pulse divider on the recovered clock strobe
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            fp_cnt_reg <= 8'h00;
            rx_frame_pulse_out <= 1'b0;
        end
        else if (ce && rx_clk_strobe)
        begin
            fp_cnt_reg <= fp_cnt_reg + 8'h01;
            rx_frame_pulse_out <= tx_alarm_reg[e1tsl_pkg::TA_FP_RATE] ?
                fp_cnt_reg[e1tsl_pkg::FP_64K_BIT] :
                (fp_cnt_reg == e1tsl_pkg::FP_8K_COUNT);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_ts16_f0;
        ce && tx_bit_strobe && tx_slot == e1tsl_pkg::SLOT_SIG
            && tx_frame == e1tsl_pkg::FRAME_ZERO && !tx_common_sig_mode
            && tx_alarm_reg[7:5] == 3'h0 && !code_loop_reg[0];
    endsequence
    sequence s_mf_release;
        ce && code_loop_reg[e1tsl_pkg::CL_MF_RESEARCH] ##1
            ce && !code_loop_reg[e1tsl_pkg::CL_MF_RESEARCH];
    endsequence
    AST_TS16_WORD: assert property (s_ts16_f0 |=>
        tx_bit_out == $past(slot16_word[3'h7 - tx_bit_idx]))
        else $error("slot 16 frame zero bit wrong");
    AST_AUTO_Y: assert property ((s_ts16_f0 and (tx_bit_idx == 3'h5 && !sig_mode_reg[0]))
        |=> tx_bit_out == $past(multiframe_loss))
        else $error("automatic remote loss bit wrong");
    AST_MF_SEARCH: assert property (s_mf_release ##1 ce |-> mf_search_start)
        else $error("multiframe search not started");
    AST_FR_SEARCH: assert property (ce && tx_alarm_reg[3] ##1 ce && !tx_alarm_reg[3]
        ##1 ce |-> frame_search_start)
        else $error("frame search not started");
    AST_ALL_ONES: assert property (ce && tx_bit_strobe && tx_alarm_reg[7]
        |=> tx_bit_out)
        else $error("all ones alarm not sent");
    AST_E_BIT: assert property (ce && tx_bit_strobe && crc_frame_loss
        |=> tx_e_bit == $past(tx_alarm_reg[4]))
        else $error("E-bit fill wrong");
    AST_DATA_OFF: assert property (ce && tx_alarm_reg[1] && frame_loss
        |=> !bp_data_out_oe)
        else $error("data output not tristated");
    AST_SIG_OFF: assert property (ce && !tx_alarm_reg[0] |=> bp_sig_out_oe)
        else $error("signalling output wrongly off");
    AST_REMOTE: assert property (ce && code_loop_reg[2] ##1 1'b1 |->
        line_tx_pos == $past(rx_pos_s))
        else $error("remote loop path wrong");
    AST_IRQ_MASK: assert property (!national_bit_link_ctrl |-> !national_link_irq)
        else $error("national link interrupt not masked");
endmodule

// >>> verif/e1tsl_far_end.sv
// Far-end E1 line terminal model: sends AMI marks, counts marks coming back
`timescale 1ns/1ps
module e1tsl_far_end
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic line_tx_pos,
    input wire logic line_tx_neg,
    output logic line_rx_pos,
    output logic line_rx_neg,
    output logic [7:0] marks_seen
);
    logic [1:0] last_reg;

    // ==========================================================
    // Sender
    // Idle line is a space on both rails
    initial {line_rx_pos, line_rx_neg} = 2'b00;

    // Marks alternate rails, ten clocks each
    task automatic send(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            line_rx_pos <= ~i[0];
            line_rx_neg <= i[0];
            repeat (9) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        {line_rx_pos, line_rx_neg} <= 2'b00;
    endtask

    // ==========================================================
    // Receiver
    // Counts rising edges on each rail
    always_ff @(posedge ref_clk)
    begin
        last_reg <= {line_tx_pos, line_tx_neg};
        if (!rst_b)
            marks_seen <= 8'h00;
        else
            marks_seen <= marks_seen + {7'h00, line_tx_pos & ~last_reg[1]}
                + {7'h00, line_tx_neg & ~last_reg[0]};
    end
endmodule

// >>> verif/test_e1_tx_signalling_loopback_ctrl.sv
// Self-checking bench for the E1 transmit signalling and loopback control block
`timescale 1ns/1ps
module test_e1_tx_signalling_loopback_ctrl;
    logic ref_clk, rst_b, ce, reg_wr, reg_rd, tx_bit_strobe, tx_framer_bit, rx_payload_bit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, marks_seen;
    logic [4:0] tx_slot;
    logic [2:0] tx_bit_idx;
    logic [3:0] tx_frame;
    logic [5:0] cond;
    logic crc_compare_bit, enc_tx_pos, enc_tx_neg, bp_data_in, rx_framer_data, rx_clk_strobe;
    logic tx_bit_out, tx_e_bit, line_rx_pos, line_rx_neg, line_tx_pos, line_tx_neg;
    logic dec_rx_pos, dec_rx_neg, bp_data_out, bp_data_out_oe, bp_sig_out, bp_sig_out_oe;
    logic hdb3_enable, rx_framing_off, tx_common_sig_mode, national_bit_link_ctrl;
    logic slot16_link_ctrl, national_link_irq, slot16_link_irq, mf_search_start;
    logic frame_search_start, rx_frame_pulse_out;
    int fails = 0, n_tests = 0;
    wire logic [6:0] ctl = {national_bit_link_ctrl, slot16_link_ctrl, national_link_irq,
        slot16_link_irq, tx_common_sig_mode, rx_framing_off, hdb3_enable};

    // ==========================================================
    // Block under test and far end
    e1tsl_ctrl e1tsl_ctrl_i (.*, .slot16_link_tx_bit(1'b0), .signal_loss(cond[0]),
        .frame_loss(cond[1]), .crc_frame_loss(cond[2]), .ais_seen(cond[3]),
        .multiframe_loss(cond[4]), .slot16_alarm_seen(cond[5]), .rx_sig_data(1'b1),
        .national_link_irq_in(1'b1), .slot16_link_irq_in(1'b1));
    e1tsl_far_end e1tsl_far_end_i (.*);

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand one cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Payload bit is the inverse of the framer bit
    task automatic txbit(input logic [4:0] s, input logic [2:0] i, input logic [3:0] f,
        input logic fb, input logic exp);
        @(posedge ref_clk);
        {tx_slot, tx_bit_idx, tx_frame, tx_framer_bit, rx_payload_bit} <= {s, i, f, fb, ~fb};
        tx_bit_strobe <= 1'b1;
        @(posedge ref_clk);
        tx_bit_strobe <= 1'b0;
        #1 chkb(tx_bit_out, exp);
    endtask
    task automatic pulses(input int n, input logic use_mf, output int p);
        p = 0;
        repeat (n)
        begin
            cyc(1);
            if ((use_mf ? mf_search_start : frame_search_start) === 1'b1)
                p++;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        logic [7:0] a [5] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
        logic [7:0] m [5] = '{8'hff, 8'he0, 8'h7f, 8'hff, 8'h03};
        logic [7:0] r [5] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
        foreach (a[k])
            rd(a[k], r[k]);
        #1 chk({1'b0, ctl}, 8'h01);
        foreach (a[k])
            wr(a[k], 8'hff);
        wr(8'h18, 8'hff);
        wr(8'h20, 8'hff);
        #1 chk({1'b0, ctl}, 8'h7e);
        foreach (a[k])
            rd(a[k], m[k]);
        rd(8'h18, 8'h00);
        rd(8'h20, 8'h00);
        foreach (a[k])
            wr(a[k], 8'h00);
        wr(8'h14, 8'h40);
        #1 chk({1'b0, ctl}, 8'h09);
        wr(8'h14, 8'h00);
    endtask
    task automatic t_mfword;
        logic [7:0] d = 8'ha5;
        wr(8'h13, d);
        wr(8'h17, 8'h01);
        for (int i = 0; i < 8; i++)
            txbit(5'h10, 3'(i), 4'h0, 1'b0, d[7 - i]);
        wr(8'h17, 8'h00);
        cond <= 6'h10;
        txbit(5'h10, 3'h5, 4'h0, 1'b0, 1'b1);
        cond <= 6'h00;
        txbit(5'h10, 3'h5, 4'h0, 1'b0, 1'b0);
        txbit(5'h10, 3'h5, 4'h1, 1'b1, 1'b1);
        wr(8'h13, 8'h0f);
    endtask
    // Whole-line alarm, slot zero alarm, slot 16 alarm, then payload loop
    task automatic t_alarm;
        wr(8'h16, 8'h80);
        txbit(5'h05, 3'h0, 4'h1, 1'b0, 1'b1);
        wr(8'h16, 8'h40);
        txbit(5'h00, 3'h3, 4'h1, 1'b0, 1'b1);
        txbit(5'h05, 3'h0, 4'h1, 1'b0, 1'b0);
        wr(8'h16, 8'h20);
        txbit(5'h10, 3'h2, 4'h3, 1'b0, 1'b1);
        txbit(5'h05, 3'h0, 4'h1, 1'b0, 1'b0);
        wr(8'h16, 8'h00);
        wr(8'h15, 8'h01);
        txbit(5'h05, 3'h0, 4'h1, 1'b0, 1'b1);
        txbit(5'h00, 3'h0, 4'h1, 1'b0, 1'b0);
        wr(8'h15, 8'h00);
    endtask
    // Each entry: sync loss, comparison result, fill bit, expected E-bit
    task automatic t_ebit;
        logic [3:0] c [4] = '{4'h5, 4'h2, 4'hb, 4'hc};
        foreach (c[k])
        begin
            wr(8'h16, {3'b000, c[k][1], 4'h0});
            cond <= {3'b000, c[k][3], 2'b00};
            crc_compare_bit <= c[k][2];
            txbit(5'h01, 3'h0, 4'h1, 1'b0, 1'b0);
            chkb(tx_e_bit, c[k][0]);
        end
        cond <= 6'h00;
        wr(8'h16, 8'h00);
    endtask
    // Request held one full frame (2500 clocks) before it is cleared
    task automatic t_reframe(input logic [7:0] a, input logic [7:0] d, input logic use_mf);
        int p;
        wr(a, d);
        pulses(2500, use_mf, p);
        chk(8'(p), 8'h00);
        wr(a, 8'h00);
        pulses(8, use_mf, p);
        chk(8'(p), 8'h01);
    endtask
    task automatic t_tristate;
        wr(8'h16, 8'h03);
        for (int i = 0; i < 6; i++)
        begin
            cond <= 6'h01 << i;
            cyc(3);
            chkb(bp_data_out_oe, i > 3);
            chkb(bp_sig_out_oe, i < 4);
        end
        cond <= 6'h3f;
        wr(8'h16, 8'h00);
        cyc(3);
        chk({6'h00, bp_data_out_oe, bp_sig_out_oe}, 8'h03);
        cond <= 6'h00;
    endtask
    task automatic t_loops;
        logic [7:0] lp [2] = '{8'h40, 8'h08};
        logic [7:0] m0;
        {enc_tx_pos, enc_tx_neg} <= 2'b10;
        cyc(6);
        chk({6'h00, dec_rx_pos, dec_rx_neg}, 8'h00);
        foreach (lp[k])
        begin
            wr(8'h15, lp[k]);
            cyc(3);
            chk({6'h00, dec_rx_pos, dec_rx_neg}, 8'h02);
        end
        wr(8'h15, 8'h00);
        {enc_tx_pos, enc_tx_neg} <= 2'b00;
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h15, k ? 8'h04 : 8'h00);
            cyc(4);
            m0 = marks_seen;
            e1tsl_far_end_i.send(4);
            cyc(12);
            chk(marks_seen - m0, k ? 8'h04 : 8'h00);
        end
        {bp_data_in, rx_framer_data} <= 2'b01;
        wr(8'h15, 8'h02);
        cyc(8);
        chkb(bp_data_out, 1'b0);
        wr(8'h15, 8'h00);
        cyc(8);
        chkb(bp_data_out, 1'b1);
    endtask
    // Toggles of the pulse output over n strobes; both rates give four here
    task automatic t_pulse(input logic [7:0] d, input int n);
        int t;
        logic prev;
        t = 0;
        wr(8'h16, d);
        rx_clk_strobe <= 1'b1;
        cyc(4);
        prev = rx_frame_pulse_out;
        repeat (n)
        begin
            cyc(1);
            if (rx_frame_pulse_out !== prev)
                t++;
            prev = rx_frame_pulse_out;
        end
        rx_clk_strobe <= 1'b0;
        chk(8'(t), 8'h04);
    endtask

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Clock, hang guard and main sequence
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // A hang counts as a mismatch
    initial
    begin
        #(50 * 100000);
        fails++;
        summarize();
    end
    initial
    begin
        {rst_b, reg_wr, reg_rd, tx_bit_strobe, tx_framer_bit, rx_payload_bit} = '0;
        {reg_addr, reg_wdata, tx_slot, tx_bit_idx, tx_frame, cond} = '0;
        {crc_compare_bit, enc_tx_pos, enc_tx_neg, bp_data_in, rx_framer_data, rx_clk_strobe} = '0;
        ce = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_regs();
        t_mfword();
        t_alarm();
        t_ebit();
        t_reframe(8'h15, 8'h10, 1'b1);
        t_reframe(8'h16, 8'h08, 1'b0);
        t_tristate();
        t_loops();
        t_pulse(8'h04, 64);
        t_pulse(8'h00, 512);
        summarize();
    end
endmodule
